// >>> rtl/amposm_top.sv
/*
 * amposm_top: operating state controller of a four-channel amplifier.
 * assumes: standby pin, audio clock presence, fault and diagnostic done
 * inputs synchronous to clk; diagnostic engines outside this block.
 */
// Operation
// (RL1) standby pin low keeps the block in standby, all amplifier functions off.
// (RL2) standby pin high enters low-power idle; protections on, commands taken.
// (RL3) in low-power idle, outputs and regulator are held at zero.
// (RL4) idle goes to amplifier mode when amp on bit set and audio clock present.
// (RL5) entering amplifier mode ramps output bias from zero to half supply.
// (RL6) host writes mute/play bits 4:3; block follows them in amplifier mode.
// (RL7) turn-on diagnostic allowed only from low-power idle; host runs it first.
// (RL8) over-current fault during play starts permanent diagnostic unasked.
// (RL9) thermal warning threshold chosen by select bits 7:6, down to 30 below.
// (RL10) diagnostic enable rising edge with amp on clear starts turn-on diagnostic.
// (RL11) completed turn-on diagnostic returns to low-power idle.
// (RL12) amp on set without audio clock waits in idle until clock appears.
`timescale 1ns/100ps
`default_nettype none
module amposm_top
    import amposm_pkg::*;
#(
    parameter int RAMP_CYCLES = BIAS_RAMP_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic [ADDR_W-1:0]       avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    standby_pin,
    input  wire logic                    audio_clk_present,
    input  wire logic                    overcurrent_fault,
    input  wire logic                    ton_diag_done,
    input  wire logic                    perm_diag_done,
    output amposm_state_e                state,
    output logic                         protections_active,
    output logic                         regulator_enable,
    output logic                         amp_stage_enable,
    output logic [BIAS_LEVEL_W-1:0]      bias_level,
    output logic [1:0]                   mute_play,
    output logic [1:0]                   thermal_warn_sel,
    output logic [5:0]                   thermal_warn_offset,
    output logic                         ton_diag_start,
    output logic                         perm_diag_start
);
    localparam int STEP_CYCLES = RAMP_CYCLES / 256;
    localparam int STEP_W      = $clog2(STEP_CYCLES + 1);

    // refuse ramps too short for one step per bias level
    if (RAMP_CYCLES < 256) begin : g_bad_ramp
        $error("RAMP_CYCLES must be at least 256");
    end

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    amposm_ctrl_s ctrl_reg, ctrl_next;
    logic         ack_reg, ack_next;
    logic [31:0]  rdata_reg, rdata_next;
    logic         diag_prev_reg, diag_prev_next;
    logic         diag_edge;
    logic         playing;
    amposm_state_e state_reg, state_next;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    always_comb begin
        ctrl_next      = ctrl_reg;
        rdata_next     = rdata_reg;
        ack_next       = (avs_read | avs_write) & ~ack_reg;
        diag_prev_next = ctrl_reg.diag_enable_bit;
        if (avs_write && !ack_reg && avs_address == CTRL_OFS && avs_byteenable[0]
            && state_reg != ST_STANDBY) begin // RL2 RL6 RL9
            ctrl_next       = amposm_ctrl_s'(avs_writedata[7:0]);
            ctrl_next.rsvd5 = 1'b0;
            ctrl_next.rsvd2 = 1'b0;
        end
        if (avs_read && !ack_reg) begin
            rdata_next = 32'h0;
            if (avs_address == CTRL_OFS) begin
                rdata_next[7:0] = ctrl_reg;
            end else if (avs_address == STATUS_OFS) begin
                rdata_next[ST_STATE_POS +: 3]  = state_reg;
                rdata_next[ST_RAMP_DONE_POS]   = (bias_level == BIAS_FULL);
                rdata_next[ST_CLK_PRES_POS]    = audio_clk_present;
                rdata_next[ST_PROT_POS]        = protections_active;
            end
        end
        if (!standby_pin) begin // RL1
            ctrl_next      = amposm_ctrl_s'(CTRL_RST);
            diag_prev_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg      <= amposm_ctrl_s'(CTRL_RST);
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0;
            diag_prev_reg <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            ack_reg       <= ack_next;
            rdata_reg     <= rdata_next;
            diag_prev_reg <= diag_prev_next;
        end
    end

    // ------------------------------------------------------------
    // operating state machine
    // ------------------------------------------------------------
    assign diag_edge = ctrl_reg.diag_enable_bit & ~diag_prev_reg & ~ctrl_reg.amp_on_bit; // RL10
    assign playing   = (ctrl_reg.mute_play != 2'h0);
    assign state     = state_reg;

    logic ton_start_reg, ton_start_next;
    logic perm_start_reg, perm_start_next;

    always_comb begin
        state_next      = state_reg;
        ton_start_next  = 1'b0;
        perm_start_next = 1'b0;
        case (state_reg)
            ST_STANDBY: begin
                state_next = ST_IDLE; // RL2
            end
            ST_IDLE: begin
                if (diag_edge) begin // RL7 RL10
                    state_next     = ST_TON_DIAG;
                    ton_start_next = 1'b1;
                end else if (ctrl_reg.amp_on_bit && audio_clk_present) begin // RL4 RL12
                    state_next = ST_AMP;
                end
            end
            ST_TON_DIAG: begin
                if (ton_diag_done) begin // RL11
                    state_next = ST_IDLE;
                end
            end
            ST_AMP: begin
                if (!ctrl_reg.amp_on_bit) begin
                    state_next = ST_IDLE;
                end else if (overcurrent_fault && playing) begin // RL8
                    state_next      = ST_PERM_DIAG;
                    perm_start_next = 1'b1;
                end
            end
            ST_PERM_DIAG: begin
                if (perm_diag_done) begin
                    state_next = ST_AMP;
                end
            end
            default: begin
                state_next = ST_STANDBY;
            end
        endcase
        if (!standby_pin) begin // RL1
            state_next      = ST_STANDBY;
            ton_start_next  = 1'b0;
            perm_start_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg      <= ST_STANDBY;
            ton_start_reg  <= 1'b0;
            perm_start_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            ton_start_reg  <= ton_start_next;
            perm_start_reg <= perm_start_next;
        end
    end

    assign ton_diag_start  = ton_start_reg;
    assign perm_diag_start = perm_start_reg;

    // ------------------------------------------------------------
    // bias ramp and output controls
    // ------------------------------------------------------------
    logic [STEP_W-1:0]       step_cnt_reg, step_cnt_next;
    logic [BIAS_LEVEL_W-1:0] bias_reg, bias_next;
    logic [1:0]              mute_reg, mute_next;
    logic [5:0]              twofs_reg, twofs_next;
    logic                    reg_en_reg, reg_en_next;
    logic                    prot_reg, prot_next;
    logic                    step_en;

    assign step_en = (step_cnt_reg == STEP_W'(STEP_CYCLES - 1));

    always_comb begin
        step_cnt_next = '0;
        bias_next     = '0; // RL1 RL3
        reg_en_next   = 1'b0;
        mute_next     = 2'h0;
        prot_next     = (state_next != ST_STANDBY); // RL2
        if (state_next == ST_AMP || state_next == ST_PERM_DIAG) begin
            reg_en_next = 1'b1;
            bias_next   = bias_reg;
            if (bias_reg != BIAS_FULL) begin // RL5
                step_cnt_next = step_en ? '0 : step_cnt_reg + 1'b1;
                if (step_en) begin
                    bias_next = bias_reg + 1'b1;
                end
            end
        end
        if (state_next == ST_AMP) begin
            mute_next = ctrl_reg.mute_play; // RL6
        end
        case (ctrl_reg.thermal_warn_sel) // RL9
            2'h0:    twofs_next = TW_OFS_0;
            2'h1:    twofs_next = TW_OFS_1;
            2'h2:    twofs_next = TW_OFS_2;
            default: twofs_next = TW_OFS_3;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            step_cnt_reg <= '0;
            bias_reg     <= '0;
            mute_reg     <= 2'h0;
            twofs_reg    <= TW_OFS_0;
            reg_en_reg   <= 1'b0;
            prot_reg     <= 1'b0;
        end else begin
            step_cnt_reg <= step_cnt_next;
            bias_reg     <= bias_next;
            mute_reg     <= mute_next;
            twofs_reg    <= twofs_next;
            reg_en_reg   <= reg_en_next;
            prot_reg     <= prot_next;
        end
    end

    assign bias_level          = bias_reg;
    assign mute_play           = mute_reg;
    assign thermal_warn_sel    = ctrl_reg.thermal_warn_sel;
    assign thermal_warn_offset = twofs_reg;
    assign regulator_enable    = reg_en_reg;
    assign amp_stage_enable    = reg_en_reg;
    assign protections_active  = prot_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_idle_to_amp;
        state_reg == ST_IDLE ##1 state_reg == ST_AMP;
    endsequence
    sequence s_diag_request;
        state_reg == ST_IDLE && diag_edge && standby_pin;
    endsequence

    property p_standby;
        @(posedge clk) disable iff (reset)
        !standby_pin |=> state_reg == ST_STANDBY ##1 (bias_reg == '0 && !reg_en_reg);
    endproperty
    a_standby: assert property (p_standby) else $error("standby not held"); // RL1

    property p_wake;
        @(posedge clk) disable iff (reset)
        state_reg == ST_STANDBY && standby_pin |=> state_reg == ST_IDLE && prot_reg;
    endproperty
    a_wake: assert property (p_wake) else $error("idle not entered"); // RL2

    property p_idle_zero;
        @(posedge clk) disable iff (reset)
        state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> bias_reg == '0 && !reg_en_reg;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle outputs not zero"); // RL3

    property p_amp_entry;
        @(posedge clk) disable iff (reset)
        s_idle_to_amp |-> $past(ctrl_reg.amp_on_bit && audio_clk_present);
    endproperty
    a_amp_entry: assert property (p_amp_entry) else $error("amp entry without cause"); // RL4

    property p_ramp;
        @(posedge clk) disable iff (reset)
        s_idle_to_amp |-> bias_reg == '0 ##1 (reg_en_reg && bias_reg <= 8'h01);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp does not start at zero"); // RL5

    property p_ramp_up;
        @(posedge clk) disable iff (reset)
        state_reg == ST_AMP && $past(state_reg) == ST_AMP |-> bias_reg >= $past(bias_reg);
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("bias fell in amp mode"); // RL5

    property p_mute;
        @(posedge clk) disable iff (reset)
        (state_reg == ST_AMP)[*2] |-> mute_reg == $past(ctrl_reg.mute_play);
    endproperty
    a_mute: assert property (p_mute) else $error("mute/play not followed"); // RL6

    property p_diag_src;
        @(posedge clk) disable iff (reset)
        $rose(ton_start_reg) |-> $past(state_reg) == ST_IDLE && !$past(ctrl_reg.amp_on_bit);
    endproperty
    a_diag_src: assert property (p_diag_src) else $error("diagnostic outside idle"); // RL7

    property p_perm;
        @(posedge clk) disable iff (reset)
        state_reg == ST_AMP && ctrl_reg.amp_on_bit && overcurrent_fault && playing
        && standby_pin |=> state_reg == ST_PERM_DIAG && perm_start_reg;
    endproperty
    a_perm: assert property (p_perm) else $error("permanent diagnostic missed"); // RL8

    property p_thermal;
        @(posedge clk) disable iff (reset)
        ctrl_reg.thermal_warn_sel == 2'h3 ##1 ctrl_reg.thermal_warn_sel == 2'h3
        |-> twofs_reg == TW_OFS_3;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal offset wrong"); // RL9

    property p_diag_start;
        @(posedge clk) disable iff (reset)
        s_diag_request |=> state_reg == ST_TON_DIAG && ton_start_reg ##1 !ton_start_reg;
    endproperty
    a_diag_start: assert property (p_diag_start) else $error("diagnostic not started"); // RL10

    property p_diag_end;
        @(posedge clk) disable iff (reset)
        state_reg == ST_TON_DIAG && ton_diag_done && standby_pin |=> state_reg == ST_IDLE;
    endproperty
    a_diag_end: assert property (p_diag_end) else $error("no return to idle"); // RL11

    property p_wait_clk;
        @(posedge clk) disable iff (reset)
        state_reg == ST_IDLE && !audio_clk_present |=> state_reg != ST_AMP;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("amp mode without clock"); // RL12

    property p_bus;
        @(posedge clk) disable iff (reset)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : amposm_top
`default_nettype wire

// >>> inc/amposm_pkg.sv
/*
 * amposm_pkg: constants, register map and types of the amplifier
 * operating state controller.
 * assumes: one 40 MHz clock, Avalon-MM register access, 32-bit data.
 */
`default_nettype none
package amposm_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ       = 40;
    localparam int BIAS_RAMP_TIME_US  = 2000;
    localparam int BIAS_RAMP_CYCLES   = BIAS_RAMP_TIME_US * CLK_FREQ_MHZ;
    localparam int BIAS_LEVEL_W       = 8;
    localparam logic [7:0] BIAS_FULL  = 8'hff;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W             = 4;
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam int AMP_ON_POS         = 0;
    localparam int DIAG_EN_POS        = 1;
    localparam int MUTE_PLAY_LO_POS   = 3;
    localparam int THERM_SEL_LO_POS   = 6;
    localparam int ST_STATE_POS       = 0;
    localparam int ST_RAMP_DONE_POS   = 3;
    localparam int ST_CLK_PRES_POS    = 4;
    localparam int ST_PROT_POS        = 5;
    // thermal warning offsets below the low protection point, degrees
    localparam logic [5:0] TW_OFS_0   = 6'h05;
    localparam logic [5:0] TW_OFS_1   = 6'h0a;
    localparam logic [5:0] TW_OFS_2   = 6'h14;
    localparam logic [5:0] TW_OFS_3   = 6'h1e;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STANDBY   = 3'h0,
        ST_IDLE      = 3'h1,
        ST_AMP       = 3'h2,
        ST_TON_DIAG  = 3'h3,
        ST_PERM_DIAG = 3'h4
    } amposm_state_e;

    typedef struct packed {
        logic [1:0] thermal_warn_sel;
        logic       rsvd5;
        logic [1:0] mute_play;
        logic       rsvd2;
        logic       diag_enable_bit;
        logic       amp_on_bit;
    } amposm_ctrl_s;
endpackage : amposm_pkg
`default_nettype wire

// >>> tb/amposm_diag_model.sv
/*
 * amposm_diag_model: stand-in for the turn-on and permanent diagnostic engines.
 * assumes: one-cycle start pulses from amposm_top, shared clock and reset.
 */
`timescale 1ns/100ps
`default_nettype none
module amposm_diag_model #(
    parameter int DIAG_CYCLES = 20
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ton_diag_start,
    input  wire logic perm_diag_start,
    output logic      ton_diag_done,
    output logic      perm_diag_done
);
    int ton_cnt;
    int perm_cnt;
    // each engine answers a start with a one-cycle done after its run
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ton_cnt        <= 0;
            perm_cnt       <= 0;
            ton_diag_done  <= 1'b0;
            perm_diag_done <= 1'b0;
        end else begin
            ton_diag_done  <= (ton_cnt == 1);
            perm_diag_done <= (perm_cnt == 1);
            ton_cnt        <= ton_diag_start ? DIAG_CYCLES : (ton_cnt > 0 ? ton_cnt - 1 : 0);
            perm_cnt       <= perm_diag_start ? DIAG_CYCLES : (perm_cnt > 0 ? perm_cnt - 1 : 0);
        end
    end
endmodule : amposm_diag_model
`default_nettype wire

// >>> tb/testbench.sv
/*
 * testbench: register-level tests of amposm_top over Avalon-MM.
 * assumes: diagnostic engine model beside it, bias ramp cut to 2560 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import amposm_pkg::*;
;
    localparam int RAMP = 2560;
    logic              clk, reset, avs_read, avs_write, avs_waitrequest;
    logic              standby_pin, audio_clk_present, overcurrent_fault;
    logic              ton_start, perm_start, ton_done, perm_done, prot, reg_en, amp_en;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rd;
    logic [7:0]        bias;
    logic [1:0]        mute_play, tw_sel;
    logic [5:0]        tw_ofs;
    amposm_state_e     state;
    int                err_count, checks_done;
    logic [5:0]        tw_exp [4] = '{6'h05, 6'h0a, 6'h14, 6'h1e};

    amposm_top #(.RAMP_CYCLES(RAMP)) i_amposm_top (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .standby_pin(standby_pin), .audio_clk_present(audio_clk_present),
        .overcurrent_fault(overcurrent_fault), .ton_diag_done(ton_done),
        .perm_diag_done(perm_done), .state(state), .protections_active(prot),
        .regulator_enable(reg_en), .amp_stage_enable(amp_en), .bias_level(bias),
        .mute_play(mute_play), .thermal_warn_sel(tw_sel), .thermal_warn_offset(tw_ofs),
        .ton_diag_start(ton_start), .perm_diag_start(perm_start)
    );
    amposm_diag_model #(.DIAG_CYCLES(20)) i_amposm_diag_model (
        .clk(clk), .reset(reset), .ton_diag_start(ton_start),
        .perm_diag_start(perm_start), .ton_diag_done(ton_done), .perm_diag_done(perm_done)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= adr;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        do begin
            @(negedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk(0, 1, "bus timeout");
        @(posedge clk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] adr, input logic [31:0] d);
        bus(1'b1, adr, d);
    endtask : wr

    task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    task automatic wait_state(input amposm_state_e exp, input int lim, input string what);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (state !== exp && n < lim);
        chk(32'(state), 32'(exp), what);
    endtask : wait_state

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #250000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        summarize();
    end

    initial begin
        int n;
        err_count = 0;
        checks_done = 0;
        reset = 1'b1;
        {avs_read, avs_write, standby_pin, audio_clk_present, overcurrent_fault} = '0;
        avs_address = '0;
        avs_writedata = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wr(CTRL_OFS, 32'h01);
        rdchk(CTRL_OFS, 32'h0, "ctrl in standby");
        chk({prot, reg_en, amp_en, bias}, 32'h0, "standby outputs");
        standby_pin <= 1'b1;
        wait_state(ST_IDLE, 5, "wake to idle");
        chk({prot, reg_en, amp_en, bias}, 32'h400, "idle outputs");
        rdchk(4'h8, 32'h0, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_OFS, 32'(i) << 6);
            repeat (2) @(negedge clk);
            chk({tw_sel, tw_ofs}, {i[1:0], tw_exp[i]}, "thermal warn");
        end
        wr(CTRL_OFS, 32'h0000_ffe4);
        rdchk(CTRL_OFS, 32'hc0, "ctrl readback");
        wr(CTRL_OFS, 32'h02);
        wait_state(ST_TON_DIAG, 5, "ton diag entry");
        wait_state(ST_IDLE, 40, "ton diag done");
        wr(CTRL_OFS, 32'h01);
        repeat (10) @(negedge clk);
        chk(32'(state), 32'(ST_IDLE), "amp on without audio clock");
        @(posedge clk);
        audio_clk_present <= 1'b1;
        wait_state(ST_AMP, 5, "amp entry");
        chk({reg_en, amp_en, bias}, 32'h300, "ramp start");
        n = 0;
        while (bias !== 8'hff && n < RAMP + 50) begin
            @(negedge clk);
            n++;
        end
        chk(n > RAMP - 50 && n < RAMP + 50, 1, "ramp length");
        rdchk(STATUS_OFS, 32'h3a, "status in amp");
        for (int m = 1; m < 4; m++) begin
            wr(CTRL_OFS, 32'h01 | (32'(m) << 3));
            repeat (2) @(negedge clk);
            chk(mute_play, m[1:0], "mute play follow");
        end
        @(posedge clk);
        overcurrent_fault <= 1'b1;
        wait_state(ST_PERM_DIAG, 5, "fault in play");
        @(posedge clk);
        overcurrent_fault <= 1'b0;
        wait_state(ST_AMP, 40, "perm diag back");
        wr(CTRL_OFS, 32'h01);
        overcurrent_fault <= 1'b1;
        repeat (5) @(negedge clk);
        chk(32'(state), 32'(ST_AMP), "fault in mute");
        @(posedge clk);
        overcurrent_fault <= 1'b0;
        wr(CTRL_OFS, 32'h03);
        repeat (5) @(negedge clk);
        chk(32'(state), 32'(ST_AMP), "diag refused in amp");
        wr(CTRL_OFS, 32'hc0);
        wait_state(ST_IDLE, 5, "amp off");
        chk({reg_en, amp_en, bias, mute_play}, 32'h0, "idle outputs off");
        @(posedge clk);
        standby_pin <= 1'b0;
        wait_state(ST_STANDBY, 5, "back to standby");
        chk({prot, reg_en, amp_en, bias}, 32'h0, "standby off");
        @(posedge clk);
        standby_pin <= 1'b1;
        wait_state(ST_IDLE, 5, "wake again");
        rdchk(CTRL_OFS, 32'h0, "ctrl cleared");
        summarize();
    end
endmodule : testbench
`default_nettype wire
